// >>> design/bmct_top.sv
// Address translation of the backplane bus interface
`timescale 1ns/10ps
`default_nettype none
`include "bmct_params.svh"
// How it works
// R1 - Sixteen-entry associative cache translates incoming DMA page addresses.
// R2 - Transfer ending on a page boundary prefetches the next page's entry.
// R3 - Miss on address bits 21:9 reads the entry from memory via map base; a page-boundary ending miss fetches only the next page's entry.
// R4 - Fetched entry is cached and the cycle proceeds only if its valid bit is set.
// R5 - Bit 33 entry flag enables the cached mapping; clear means consult memory.
// R6 - Flags clear on reset, power-good loss, flush, I/O reset, base or entry writes.
// R7 - Entry bits 32:20 hold bus page bits 21:9 and are compared associatively.
// R8 - Hit forms memory bits 28:9 from entry page, passes bits 8:0.
// R9 - I/O window local addresses copy bits 12:0 and assert I/O page select.
// R10 - I/O window accesses drive backplane bits 21:13 as zero.
// R11 - Memory window local addresses copy bits 21:0 to backplane.
// R12 - Device is always the bus arbiter; no auxiliary mode.
// R13 - Communication register gives other processors interrupts and memory access control.
// R14 - Sixteen-bit communication register in bus I/O space, reachable by any master.
// R15 - Byte writes change only the addressed byte.
// R16 - Register decodes at fixed local and bus addresses.
// R17 - Entry with valid bit clear: no bus response to that page.
// R18 - Writing one to bit 14 flushes all flags; reads zero.
// R19 - Round-robin victim when a new entry must be cached.
module bmct_top
  import bmct_pkg::*;
#(
  parameter int ENTRIES = `BMCT_ENTRIES
) (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic i_power_good_input,
  input wire logic i_peripheral_reset_write,
  input wire logic i_map_base_write,
  input wire logic i_map_entry_write,
  input wire logic [12:0] i_map_entry_write_tag,
  // DMA request from the backplane
  input wire logic i_dma_req,
  input wire logic [21:0] i_dma_addr,
  input wire logic i_dma_end,
  output logic o_dma_ack,
  output logic o_dma_no_resp,
  output logic [28:0] o_mem_addr,
  // Map entry fetch from main memory
  output logic o_map_rd_req,
  output logic [12:0] o_map_rd_index,
  input wire logic i_map_rd_done,
  input wire logic [31:0] i_map_rd_data,
  // CPU local bus outbound translation
  input wire logic [31:0] i_cpu_local_bus_addr,
  output logic o_bus_valid,
  output logic [21:0] o_bus_addr,
  output logic o_io_page_select,
  // Communication register access from any bus master
  input wire logic i_comm_sel_local,
  input wire logic i_comm_sel_bus,
  input wire logic [31:0] i_comm_local_addr,
  input wire logic [21:0] i_comm_bus_addr,
  input wire logic i_comm_wr,
  input wire logic [1:0] i_comm_be,
  input wire logic [15:0] i_comm_wdata,
  output logic [15:0] o_comm_rdata,
  output logic o_comm_hit,
  output logic o_arbiter
);
  bmct_lookup_if lk ();
  bmct_state_t state_q;
  logic [21:0] req_addr_q;
  logic prefetch_q;
  logic [15:0] comm_q;
  logic comm_wr_hit;
  logic flush;
  logic [12:0] fetch_tag;
  logic fetch_valid;
  // Mask held at register width so the low-byte slice is taken explicitly
  localparam logic [15:0] COMM_MASK = `BMCT_COMM_RW_MASK;

  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  bmct_cam #(.ENTRIES(ENTRIES)) u_cam (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .lk(lk.cam)
  );

  // ****************************************
  // Invalidation sources
  // ****************************************
  // Power-good loss acts like reset for the flags
  assign comm_wr_hit = i_comm_wr && o_comm_hit;
  assign flush = !i_power_good_input || i_peripheral_reset_write || i_map_base_write ||
                 (comm_wr_hit && i_comm_be[1] && i_comm_wdata[`BMCT_FLUSH_BIT]); // R6 R18
  assign lk.flush = flush;
  assign lk.kill = i_map_entry_write; // R6
  assign lk.kill_tag = i_map_entry_write_tag;

  // ****************************************
  // DMA lookup and miss refill
  // ****************************************
  assign fetch_tag = prefetch_q ? req_addr_q[21:9] + 13'h0001 : req_addr_q[21:9];
  assign fetch_valid = i_map_rd_data[`BMCT_MAP_VALID_BIT];
  assign lk.look_tag = i_dma_addr[21:9]; // R3
  assign lk.fill = (state_q == BMCT_READ) && i_map_rd_done && fetch_valid && !flush; // R4
  assign lk.fill_tag = fetch_tag;
  assign lk.fill_page = i_map_rd_data[19:0];
  assign o_map_rd_req = (state_q == BMCT_READ);
  assign o_map_rd_index = fetch_tag; // R3

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_q <= BMCT_IDLE;
      prefetch_q <= 1'b0;
      req_addr_q <= '0;
    end else begin
      unique case (state_q)
        BMCT_IDLE: begin
          if (i_dma_req && i_dma_end && i_dma_addr[8:0] == 9'h1ff) begin
            // Prefetch before the next transfer may begin
            state_q <= BMCT_READ; // R2
            prefetch_q <= 1'b1;
            req_addr_q <= i_dma_addr;
          end else if (i_dma_req && !lk.hit) begin
            state_q <= BMCT_READ; // R3
            prefetch_q <= 1'b0;
            req_addr_q <= i_dma_addr;
          end
        end
        BMCT_READ: begin
          if (i_map_rd_done) begin
            state_q <= BMCT_DONE;
          end
        end
        BMCT_DONE: begin
          state_q <= BMCT_IDLE;
        end
        default: state_q <= BMCT_IDLE;
      endcase
    end
  end

  // Miss answer is given once a non-prefetch fetch completes; invalid entry means no response
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      o_dma_ack <= 1'b0;
      o_dma_no_resp <= 1'b0;
      o_mem_addr <= '0;
    end else begin
      o_dma_ack <= 1'b0;
      o_dma_no_resp <= 1'b0;
      if (state_q == BMCT_IDLE && i_dma_req && lk.hit &&
          !(i_dma_end && i_dma_addr[8:0] == 9'h1ff)) begin
        o_dma_ack <= 1'b1;
        o_mem_addr <= {lk.hit_page, i_dma_addr[8:0]}; // R8 R1
      end else if (state_q == BMCT_IDLE && i_dma_req && lk.hit) begin
        o_dma_ack <= 1'b1;
        o_mem_addr <= {lk.hit_page, i_dma_addr[8:0]}; // R8
      end else if (state_q == BMCT_READ && i_map_rd_done && !prefetch_q) begin
        if (fetch_valid) begin
          o_dma_ack <= 1'b1; // R4
          o_mem_addr <= {i_map_rd_data[19:0], req_addr_q[8:0]};
        end else begin
          o_dma_no_resp <= 1'b1; // R17
        end
      end
    end
  end

  // ****************************************
  // Outbound local bus translation
  // ****************************************
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      o_bus_valid <= 1'b0;
      o_bus_addr <= '0;
      o_io_page_select <= 1'b0;
    end else if (in_range(i_cpu_local_bus_addr, `BMCT_IO_WIN_LO, `BMCT_IO_WIN_HI)) begin
      o_bus_valid <= 1'b1;
      o_bus_addr <= {9'h000, i_cpu_local_bus_addr[12:0]}; // R9 R10
      o_io_page_select <= 1'b1; // R9
    end else if (in_range(i_cpu_local_bus_addr, `BMCT_MEM_WIN_LO, `BMCT_MEM_WIN_HI)) begin
      o_bus_valid <= 1'b1;
      o_bus_addr <= i_cpu_local_bus_addr[21:0]; // R11
      o_io_page_select <= 1'b0;
    end else begin
      o_bus_valid <= 1'b0;
      o_bus_addr <= '0;
      o_io_page_select <= 1'b0;
    end
  end

  // ****************************************
  // Communication register
  // ****************************************
  // Fixed address because auxiliary mode does not exist
  assign o_arbiter = 1'b1; // R12
  assign o_comm_hit = (i_comm_sel_local && i_comm_local_addr == `BMCT_COMM_ADDR) ||
                      (i_comm_sel_bus && i_comm_bus_addr == `BMCT_COMM_BUS_ADDR); // R16 R14

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      comm_q <= '0;
    end else if (!i_power_good_input) begin
      comm_q <= '0;
    end else if (comm_wr_hit) begin
      // Only storable bits kept; the flush bit never stores so it reads zero
      if (i_comm_be[0]) begin
        comm_q[7:0] <= i_comm_wdata[7:0] & COMM_MASK[7:0]; // R15 R13
      end
      if (i_comm_be[1]) begin
        comm_q[15:8] <= 8'h00; // R15 R18
      end
    end
  end
  assign o_comm_rdata = comm_q; // R14
endmodule
`default_nettype wire

// >>> common/bmct_params.svh
// Constants of the bus map cache translation block
`ifndef BMCT_PARAMS_SVH
`define BMCT_PARAMS_SVH
`define BMCT_ENTRIES 16
`define BMCT_ENTRY_VALID_BIT 33
`define BMCT_TAG_HI 32
`define BMCT_TAG_LO 20
`define BMCT_PAGE_HI 19
`define BMCT_PAGE_LO 0
`define BMCT_IO_WIN_LO 32'h20000000
`define BMCT_IO_WIN_HI 32'h20001fff
`define BMCT_MEM_WIN_LO 32'h30000000
`define BMCT_MEM_WIN_HI 32'h303fffff
`define BMCT_COMM_ADDR 32'h20001f40
`define BMCT_COMM_BUS_ADDR 22'h3fff40
`define BMCT_FLUSH_BIT 4'he
`define BMCT_COMM_RW_MASK 16'h0061
`define BMCT_MAP_VALID_BIT 31
`endif

// >>> common/bmct_pkg.sv
// Types of the bus map cache translation block
package bmct_pkg;
  typedef logic [12:0] bmct_tag_t;
  typedef logic [19:0] bmct_page_t;
  typedef enum logic [1:0] {
    BMCT_IDLE = 2'b00,
    BMCT_READ = 2'b01,
    BMCT_DONE = 2'b11
  } bmct_state_t;
endpackage

// >>> common/bmct_lookup_if.sv
// Lookup carrier between the controller and the associative array
`timescale 1ns/10ps
`default_nettype none
interface bmct_lookup_if;
  import bmct_pkg::*;
  bmct_tag_t look_tag;
  logic hit;
  bmct_page_t hit_page;
  logic fill;
  bmct_tag_t fill_tag;
  bmct_page_t fill_page;
  logic flush;
  logic kill;
  bmct_tag_t kill_tag;
  modport ctrl(output look_tag, fill, fill_tag, fill_page, flush, kill, kill_tag,
    input hit, hit_page);
  modport cam(input look_tag, fill, fill_tag, fill_page, flush, kill, kill_tag,
    output hit, hit_page);
endinterface
`default_nettype wire

// >>> design/bmct_cam.sv
// Sixteen-entry fully associative map cache
`timescale 1ns/10ps
`default_nettype none
`include "bmct_params.svh"
module bmct_cam
  import bmct_pkg::*;
#(
  parameter int ENTRIES = `BMCT_ENTRIES
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  bmct_lookup_if.cam lk
);
  localparam int IW = $clog2(ENTRIES);
  // Entry layout: flag, tag, memory page
  logic [`BMCT_ENTRY_VALID_BIT:0] entry_q [ENTRIES];
  logic [IW-1:0] victim_q;
  logic [ENTRIES-1:0] match;

  // ****************************************
  // Associative compare
  // ****************************************
  always_comb begin
    lk.hit = 1'b0;
    lk.hit_page = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      match[i] = entry_q[i][`BMCT_ENTRY_VALID_BIT] &&
                 entry_q[i][`BMCT_TAG_HI:`BMCT_TAG_LO] == lk.look_tag; // R7 R5
      if (match[i]) begin
        lk.hit = 1'b1;
        lk.hit_page = entry_q[i][`BMCT_PAGE_HI:`BMCT_PAGE_LO]; // R1
      end
    end
  end

  // ****************************************
  // Fill, replacement and invalidation
  // ****************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < ENTRIES; i++) begin
        entry_q[i] <= '0; // R6
      end
    end else if (lk.flush) begin
      for (int i = 0; i < ENTRIES; i++) begin
        entry_q[i][`BMCT_ENTRY_VALID_BIT] <= 1'b0; // R6 R18
      end
    end else begin
      for (int i = 0; i < ENTRIES; i++) begin
        if (lk.kill && entry_q[i][`BMCT_TAG_HI:`BMCT_TAG_LO] == lk.kill_tag) begin
          entry_q[i][`BMCT_ENTRY_VALID_BIT] <= 1'b0; // R6
        end
      end
      if (lk.fill) begin
        entry_q[victim_q] <= {1'b1, lk.fill_tag, lk.fill_page}; // R4
      end
    end
  end

  // Round robin keeps the victim choice free of any usage tracking
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      victim_q <= '0;
    end else if (lk.fill) begin
      victim_q <= victim_q + 1'b1; // R19
    end
  end
endmodule
`default_nettype wire

// >>> testbench/bmct_top_properties.sv
// Port checker of the bus map cache translation block
`timescale 1ns/10ps
`default_nettype none
`include "bmct_params.svh"
module bmct_top_properties (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic i_power_good_input,
  input wire logic i_dma_req,
  input wire logic [21:0] i_dma_addr,
  input wire logic o_dma_ack,
  input wire logic o_dma_no_resp,
  input wire logic [28:0] o_mem_addr,
  input wire logic [31:0] i_cpu_local_bus_addr,
  input wire logic [21:0] o_bus_addr,
  input wire logic o_io_page_select,
  input wire logic [15:0] o_comm_rdata,
  input wire logic o_arbiter
);
  // ************
  // Relations
  // ************
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);
  sequence s_req_start;
    !i_dma_req ##1 i_dma_req;
  endsequence
  arbiter_mode_a: assert property (o_arbiter) else $error("arbiter low");
  io_window_a: assert property (i_cpu_local_bus_addr inside {[`BMCT_IO_WIN_LO:`BMCT_IO_WIN_HI]}
    |=> o_io_page_select && o_bus_addr == {9'h0, $past(i_cpu_local_bus_addr[12:0])}) else $error("io");
  mem_window_a: assert property (i_cpu_local_bus_addr inside {[`BMCT_MEM_WIN_LO:`BMCT_MEM_WIN_HI]}
    |=> !o_io_page_select && o_bus_addr == $past(i_cpu_local_bus_addr[21:0])) else $error("mem");
  offset_pass_a: assert property (o_dma_ack |-> o_mem_addr[8:0] == $past(i_dma_addr[8:0]))
    else $error("offset");
  dma_answer_a: assert property (s_req_start |-> ##[1:40] (o_dma_ack || o_dma_no_resp))
    else $error("no answer");
  one_answer_a: assert property (!(o_dma_ack && o_dma_no_resp)) else $error("both");
  unused_zero_a: assert property ((o_comm_rdata & ~`BMCT_COMM_RW_MASK) == 16'h0)
    else $error("unused bits");
  power_loss_a: assert property (!i_power_good_input |=> o_comm_rdata == 16'h0)
    else $error("power loss");
endmodule
bind bmct_top bmct_top_properties bmct_top_properties_inst (.*);
`default_nettype wire

// >>> testbench/bmct_mem_model.sv
// Main memory map partner answering entry reads
`timescale 1ns/10ps
`default_nettype none
module bmct_mem_model (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_req,
  input wire logic [12:0] i_index,
  output logic o_done,
  output logic [31:0] o_data
);
  // ************
  // Map store
  // ************
  logic [2:0] cnt_q;
  logic [31:0] entry;
  // Top tag bit marks an unmapped page; odd tags answer slowly
  assign entry = {!i_index[12], 11'h0, 7'h55, i_index};
  assign o_done = i_req && cnt_q == (i_index[0] ? 3'h4 : 3'h1);
  // Inverted off the done cycle so a stale sample cannot pass
  assign o_data = o_done ? entry : ~entry;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) cnt_q <= 3'h0;
    else cnt_q <= (i_req && !o_done) ? cnt_q + 3'h1 : 3'h0;
  end
endmodule
`default_nettype wire

// >>> testbench/test_bmct_top.sv
// Self-checking bench of the bus map cache translation block
`timescale 1ns/10ps
`default_nettype none
`include "bmct_params.svh"
module test_bmct_top;
  logic I_CLK = 0, I_ARST_N = 0, i_power_good_input = 1, i_peripheral_reset_write = 0;
  logic i_map_base_write = 0, i_map_entry_write = 0, i_dma_req = 0, i_dma_end = 0;
  logic i_comm_sel_local = 0, i_comm_sel_bus = 0, i_comm_wr = 0, i_map_rd_done, o_arbiter;
  logic o_dma_ack, o_dma_no_resp, o_map_rd_req, o_bus_valid, o_io_page_select, o_comm_hit;
  logic [1:0] i_comm_be = 0;
  logic [12:0] i_map_entry_write_tag = 13'h8, o_map_rd_index;
  logic [15:0] i_comm_wdata = 0, o_comm_rdata;
  logic [21:0] i_dma_addr = 0, o_bus_addr, i_comm_bus_addr = `BMCT_COMM_BUS_ADDR;
  logic [28:0] o_mem_addr;
  logic [31:0] i_map_rd_data, i_cpu_local_bus_addr = 0, i_comm_local_addr = `BMCT_COMM_ADDR;
  int error_cnt = 0, checks_done = 0, fetches = 0;
  bmct_top bmct_top_inst (.*);
  bmct_mem_model bmct_mem_model_inst (.i_clk(I_CLK), .i_arst_n(I_ARST_N), .i_req(o_map_rd_req),
    .i_index(o_map_rd_index), .o_done(i_map_rd_done), .o_data(i_map_rd_data));
  always #10 I_CLK = ~I_CLK;
  always @(posedge I_CLK) if (o_map_rd_req && i_map_rd_done) fetches++;
  // ************
  // Tasks
  // ************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    if (seen !== exp) error_cnt++;
  endtask
  // Request is held until an answer shows, then dropped on the next falling edge
  task dma(input logic [21:0] a, input logic e, input logic ok);
    @(negedge I_CLK) {i_dma_req, i_dma_addr, i_dma_end} = {1'h1, a, e};
    repeat (60) @(posedge I_CLK) #1 if (o_dma_ack === 1'h1 || o_dma_no_resp === 1'h1) break;
    chk(o_dma_ack, ok);
    chk(o_dma_no_resp, !ok);
    if (ok) chk(o_mem_addr, {7'h55, a});
    @(negedge I_CLK) {i_dma_req, i_dma_end} = 2'h0;
  endtask
  task cw(input logic loc, input logic [1:0] be, input logic [15:0] d);
    @(negedge I_CLK) {i_comm_sel_local, i_comm_sel_bus, i_comm_wr} = {loc, !loc, 1'h1};
    {i_comm_be, i_comm_wdata} = {be, d};
    #1 chk(o_comm_hit, 1);
    @(negedge I_CLK) {i_comm_sel_local, i_comm_sel_bus, i_comm_wr} = 3'h0;
  endtask
  task t_xlate;
    logic [31:0] a [4];
    a = '{32'h20000000, 32'h20001fff, 32'h30000000, 32'h303fffff};
    for (int i = 0; i < 4; i++) begin
      @(negedge I_CLK) i_cpu_local_bus_addr = a[i];
      @(negedge I_CLK) chk(o_bus_addr, i < 2 ? {9'h0, a[i][12:0]} : a[i][21:0]);
      chk(o_io_page_select, i < 2);
      chk(o_bus_valid, 1);
    end
    @(negedge I_CLK) i_cpu_local_bus_addr = 32'h30400000;
    @(negedge I_CLK) chk(o_bus_valid, 0);
    chk(o_io_page_select, 0);
    chk(o_arbiter, 1);
    $display("Translation test done");
  endtask
  task t_dma;
    int f;
    f = fetches;
    dma(22'h0a5e3, 0, 1);
    dma(22'h0a401, 0, 1);
    chk(fetches, f + 1);
    dma(22'h200000, 0, 0);
    dma(22'h200000, 0, 0);
    chk(fetches, f + 3);
    $display("Lookup test done");
  endtask
  // Each flush source in turn must force a refetch of a cached page
  task t_flush;
    int f;
    for (int k = 0; k < 5; k++) begin
      dma(22'h1000, 0, 1);
      f = fetches;
      @(negedge I_CLK);
      case (k)
        0: i_peripheral_reset_write = 1;
        1: i_map_base_write = 1;
        2: i_map_entry_write = 1;
        3: cw(1, 2'h2, 16'h4000);
        default: i_power_good_input = 0;
      endcase
      @(negedge I_CLK) {i_peripheral_reset_write, i_map_base_write, i_map_entry_write} = 3'h0;
      i_power_good_input = 1;
      dma(22'h1000, 0, 1);
      chk(fetches, f + 1);
    end
    $display("Flush test done");
  endtask
  task t_prefetch;
    int f;
    dma(22'h04000, 0, 1);
    f = fetches;
    dma(22'h041ff, 1, 1);
    repeat (12) @(negedge I_CLK);
    chk(fetches, f + 1);
    dma(22'h04200, 0, 1);
    chk(fetches, f + 1);
    $display("Prefetch test done");
  endtask
  // Seventeen new pages wrap the round-robin pointer onto the first one
  task t_victim;
    int f;
    for (int k = 0; k < 17; k++) dma(22'h20000 + 22'(k) * 22'h400, 0, 1);
    f = fetches;
    dma(22'h20800, 0, 1);
    chk(fetches, f);
    dma(22'h20000, 0, 1);
    chk(fetches, f + 1);
    $display("Replacement test done");
  endtask
  task t_comm;
    cw(1, 2'h1, 16'hffff);
    chk(o_comm_rdata, 16'h0061);
    cw(0, 2'h2, 16'hff00);
    chk(o_comm_rdata, 16'h0061);
    cw(0, 2'h1, 16'h0000);
    chk(o_comm_rdata, 16'h0000);
    $display("Register test done");
  endtask
  task test_done;
    $display("Checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge I_CLK);
    @(negedge I_CLK) I_ARST_N = 1;
    t_xlate;
    t_dma;
    t_flush;
    t_prefetch;
    t_victim;
    t_comm;
    test_done;
  end
  initial begin
    #100000 error_cnt++;
    test_done;
  end
endmodule
`default_nettype wire
